// *** src/brs_pkg.sv ***
package brs_pkg;
	// Reply framing bytes
	localparam logic [7:0] DATA_PACKET_START = 8'h81;
	localparam logic [7:0] PACKET_END = 8'h03;
	localparam logic [7:0] LENGTH_HIGH = 8'h00;
	localparam logic [7:0] LENGTH_LOW = 8'h0a;
	localparam logic [7:0] ERROR_FLAG = 8'h80;
	localparam logic [3:0] REPLY_BYTES = 4'hf;
	localparam logic [3:0] LAST_INDEX = 4'he;
	localparam logic [3:0] FIRST_SUMMED = 4'h1;
	// Unused code for detail and address fields, as printed
	localparam logic [31:0] UNUSED_CODE = 32'h0fffffff;
	// Status codes
	localparam logic [7:0] ST_OK = 8'h00;
	localparam logic [7:0] ST_UNSUPPORTED = 8'hc0;
	localparam logic [7:0] ST_PACKET = 8'hc1;
	localparam logic [7:0] ST_CHECKSUM = 8'hc2;
	localparam logic [7:0] ST_PARAMETER = 8'hd0;
	localparam logic [7:0] ST_ACCEPTANCE = 8'hd5;
	localparam logic [7:0] ST_LC_UNMATCHED = 8'hd6;
	localparam logic [7:0] ST_HARDWARE = 8'hd7;
	localparam logic [7:0] ST_PROTECTION = 8'hda;
	localparam logic [7:0] ST_TRUSTED = 8'hdb;
	localparam logic [7:0] ST_ID_DISCORD = 8'hdd;
	localparam logic [7:0] ST_SERIAL_DISABLED = 8'hde;
	localparam logic [7:0] ST_SECURE = 8'he4;
	localparam logic [7:0] ST_FLASH_ACCESS = 8'he5;
	// Lifecycle state codes
	localparam logic [7:0] LC_CHIP_MANUFACTURING = 8'h01;
	localparam logic [7:0] LC_SECURE_DEVELOPMENT = 8'h02;
	localparam logic [7:0] LC_NONSECURE_DEVELOPMENT = 8'h03;
	localparam logic [7:0] LC_DEPLOYED = 8'h04;
	localparam logic [7:0] LC_LOCKED_DEBUG = 8'h05;
	localparam logic [7:0] LC_LOCKED_BOOT = 8'h06;
	localparam logic [7:0] LC_RETURN_REQUESTED = 8'h07;
	localparam logic [7:0] LC_RETURN_ACKNOWLEDGED = 8'h08;
	// Packet size limits seen by the command side
	localparam int MAX_PACKET_LEN = 1025;
	localparam int MAX_TRANSFER = 1030;
	localparam int MAX_DATA_FIELD = 1024;
	// Encoder sequencing
	typedef enum logic [2:0] {
		BRS_IDLE = 3'b001,
		BRS_SEND = 3'b010,
		BRS_CLEAR = 3'b100
	} brs_state_t;
endpackage : brs_pkg

// *** src/brs_stream_if.sv ***
`timescale 1ns/1ns
interface brs_stream_if #(
	parameter int WIDTH = 8
);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : brs_stream_if

// *** src/brs_fifo.sv ***
`timescale 1ns/1ns
module brs_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	brs_stream_if.snk push,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	// Refuse depths the wrap-bit pointers cannot serve
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
		$error("brs_fifo: DEPTH must be a power of two >= 2");
	end
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic full;
	logic empty;
	logic do_push;
	logic do_pop;
	// Pointers carry one extra wrap bit to tell full from empty
	assign empty = (wr_q == rd_q);
	assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	assign push.ready = !full;
	assign do_push = push.valid && !full;
	assign out_valid_o = !empty;
	assign do_pop = out_ready_i && !empty;
	assign out_data_o = mem_q[rd_q[AW-1:0]];
	// Storage write
	always_ff @(posedge clk_i) begin
		if (do_push) begin
			mem_q[wr_q[AW-1:0]] <= push.data;
		end
	end
	// Pointer update
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (do_push) wr_q <= wr_q + (AW+1)'(1);
			if (do_pop) rd_q <= rd_q + (AW+1)'(1);
		end
	end
endmodule : brs_fifo

// *** src/brs_encoder.sv ***
// Behaviour
// - Response code is command code, or command code OR 0x80 on error.
// - Data field of a data packet carries 1 to 1024 bytes.
// - Status 0x00 normal, 0xC0 unsupported, 0xC1 packet, 0xC2 checksum.
// - Status 0xD0 bad parameter, 0xD5 command not permitted in current state.
// - Lifecycle groups: 0xD6 stored/monitor mismatch, 0xD7 abnormal stored lifecycle (here 0xD7 is set by a lifecycle monitor code outside 0x01 to 0x08).
// - Status 0xDA for protected region or prohibited action.
// - Status 0xE4 when erase, write or key injection touches secure region.
// - Status 0xDB when trusted security subsystem flags an abnormality.
// - ID group: 0xDD on ID failure, 0xDE when stored ID bit 127 is 0.
// - Status 0xE5 when flash sequencer enters command-lock state.
// - Any nonzero status marks the response code as error.
// - Flash access error also returns detail word and failure address.
// - Detail word is flash status on flash error, else unused code.
// - Flash status is cleared after the status reply is sent (here once its last byte is queued in the FIFO).
// - Failure address is failing command start, else unused code.
// - Lifecycle state codes 0x01 to 0x08 in one byte.
// - Acceptance uses lifecycle state, or ID authentication state without lifecycle.
// - Unavailable on device gives unsupported; unavailable in state gives acceptance error.
// - Reply framed 0x81, length, code, data, checksum, 0x03; sum from length is zero.
// - Locked-boot state never reaches command acceptance.
`timescale 1ns/1ns
module brs_encoder #(
	parameter bit LC_CAPABLE = 1'b1,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// Request from the command processor
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire logic [7:0] cmd_code_i,
	input wire logic cmd_supported_i,
	input wire logic err_packet_i,
	input wire logic err_checksum_i,
	input wire logic err_param_i,
	input wire logic err_protect_i,
	input wire logic err_secure_i,
	input wire logic trusted_fault_i,
	input wire logic id_auth_fail_i,
	// Acceptance inputs
	input wire logic [7:0] cmd_lc_mask_i,
	input wire logic [1:0] cmd_auth_mask_i,
	input wire logic id_authenticated_i,
	input wire logic stored_id_top_i,
	input wire logic [7:0] lifecycle_monitor_i,
	input wire logic [7:0] stored_lifecycle_info_i,
	// Flash sequencer
	input wire logic flash_cmd_lock_i,
	input wire logic [31:0] flash_status_word_i,
	input wire logic [31:0] flash_fail_addr_i,
	output logic flash_status_clear_o,
	// Reply summary
	output logic [7:0] response_code_o,
	output logic [7:0] status_code_o,
	output logic [7:0] lifecycle_state_o,
	// Reply byte stream
	output logic tx_valid_o,
	input wire logic tx_ready_i,
	output logic [7:0] tx_data_o
);
	// Refuse buffer depths outside what the reply buffer supports
	if (FIFO_DEPTH < 2 || FIFO_DEPTH > 256) begin : g_depth_check
		$error("brs_encoder: FIFO_DEPTH out of range");
	end

	brs_pkg::brs_state_t state_q;
	brs_pkg::brs_state_t state_d;
	logic [3:0] idx_q;
	logic [7:0] sum_q;
	logic [7:0] resp_q;
	logic [7:0] status_q;
	logic [31:0] detail_q;
	logic [31:0] addr_q;
	logic [7:0] lc_q;
	logic [7:0] status_d;
	logic [7:0] cur_byte;
	logic lc_valid;
	logic lc_accept;
	logic auth_accept;
	logic accepted;
	logic take;
	logic push_ok;

	brs_stream_if #(.WIDTH(8)) tx_if ();

	brs_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.push(tx_if.snk),
		.out_valid_o(tx_valid_o),
		.out_ready_i(tx_ready_i),
		.out_data_o(tx_data_o)
	);

	// A request is only taken between replies
	assign req_ready_o = (state_q == brs_pkg::BRS_IDLE);
	assign take = req_valid_i && req_ready_o;

	// Lifecycle code must fall in the defined range
	assign lc_valid = (lifecycle_monitor_i >= brs_pkg::LC_CHIP_MANUFACTURING) &&
		(lifecycle_monitor_i <= brs_pkg::LC_RETURN_ACKNOWLEDGED);

	// Per-state availability, mask bit n-1 for lifecycle code n
	always_comb begin
		lc_accept = 1'b0;
		if (lc_valid && lifecycle_monitor_i != brs_pkg::LC_LOCKED_BOOT) begin
			lc_accept = cmd_lc_mask_i[3'(lifecycle_monitor_i - 8'h01)];
		end
	end
	assign auth_accept = cmd_auth_mask_i[id_authenticated_i];
	assign accepted = LC_CAPABLE ? lc_accept : auth_accept;

	// Status selection in reply priority order
	always_comb begin
		status_d = brs_pkg::ST_OK;
		if (!cmd_supported_i) begin
			status_d = brs_pkg::ST_UNSUPPORTED;
		end else if (err_packet_i) begin
			status_d = brs_pkg::ST_PACKET;
		end else if (err_checksum_i) begin
			status_d = brs_pkg::ST_CHECKSUM;
		end else if (LC_CAPABLE && !lc_valid) begin
			status_d = brs_pkg::ST_HARDWARE;
		end else if (LC_CAPABLE && stored_lifecycle_info_i != lifecycle_monitor_i) begin
			status_d = brs_pkg::ST_LC_UNMATCHED;
		end else if (!LC_CAPABLE && !stored_id_top_i) begin
			status_d = brs_pkg::ST_SERIAL_DISABLED;
		end else if (!accepted) begin
			status_d = brs_pkg::ST_ACCEPTANCE;
		end else if (err_param_i) begin
			status_d = brs_pkg::ST_PARAMETER;
		end else if (!LC_CAPABLE && id_auth_fail_i) begin
			status_d = brs_pkg::ST_ID_DISCORD;
		end else if (err_secure_i && LC_CAPABLE) begin
			status_d = brs_pkg::ST_SECURE;
		end else if (err_protect_i) begin
			status_d = brs_pkg::ST_PROTECTION;
		end else if (trusted_fault_i) begin
			status_d = brs_pkg::ST_TRUSTED;
		end else if (flash_cmd_lock_i) begin
			status_d = brs_pkg::ST_FLASH_ACCESS;
		end
	end

	// Capture the reply contents when a request is taken
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			resp_q <= 8'h00;
			status_q <= brs_pkg::ST_OK;
			detail_q <= brs_pkg::UNUSED_CODE;
			addr_q <= brs_pkg::UNUSED_CODE;
		end else if (take) begin
			status_q <= status_d;
			if (status_d != brs_pkg::ST_OK) begin
				resp_q <= cmd_code_i | brs_pkg::ERROR_FLAG;
			end else begin
				resp_q <= cmd_code_i;
			end
			if (status_d == brs_pkg::ST_FLASH_ACCESS) begin
				detail_q <= flash_status_word_i;
				addr_q <= flash_fail_addr_i;
			end else begin
				detail_q <= brs_pkg::UNUSED_CODE;
				addr_q <= brs_pkg::UNUSED_CODE;
			end
		end
	end

	// Lifecycle code reported alongside the reply
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lc_q <= 8'h00;
		end else if (take) begin
			lc_q <= lc_valid ? lifecycle_monitor_i : 8'h00;
		end
	end

	assign response_code_o = resp_q;
	assign status_code_o = status_q;
	assign lifecycle_state_o = lc_q;

	// Byte at the current position of the reply
	always_comb begin
		unique case (idx_q)
			4'h0: cur_byte = brs_pkg::DATA_PACKET_START;
			4'h1: cur_byte = brs_pkg::LENGTH_HIGH;
			4'h2: cur_byte = brs_pkg::LENGTH_LOW;
			4'h3: cur_byte = resp_q;
			4'h4: cur_byte = status_q;
			4'h5: cur_byte = detail_q[31:24];
			4'h6: cur_byte = detail_q[23:16];
			4'h7: cur_byte = detail_q[15:8];
			4'h8: cur_byte = detail_q[7:0];
			4'h9: cur_byte = addr_q[31:24];
			4'ha: cur_byte = addr_q[23:16];
			4'hb: cur_byte = addr_q[15:8];
			4'hc: cur_byte = addr_q[7:0];
			4'hd: cur_byte = 8'h00 - sum_q;
			default: cur_byte = brs_pkg::PACKET_END;
		endcase
	end

	// Push into the FIFO; a full FIFO stalls the sequence
	assign tx_if.valid = (state_q == brs_pkg::BRS_SEND);
	assign tx_if.data = cur_byte;
	assign push_ok = tx_if.valid && tx_if.ready;

	// Sequencer next state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			brs_pkg::BRS_IDLE: begin
				if (take) state_d = brs_pkg::BRS_SEND;
			end
			brs_pkg::BRS_SEND: begin
				if (push_ok && idx_q == brs_pkg::LAST_INDEX) state_d = brs_pkg::BRS_CLEAR;
			end
			brs_pkg::BRS_CLEAR: begin
				state_d = brs_pkg::BRS_IDLE;
			end
			default: state_d = brs_pkg::BRS_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= brs_pkg::BRS_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Byte position within the reply
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			idx_q <= 4'h0;
		end else if (take) begin
			idx_q <= 4'h0;
		end else if (push_ok) begin
			idx_q <= idx_q + 4'h1;
		end
	end

	// Running sum from the length bytes up to the last data byte
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sum_q <= 8'h00;
		end else if (take) begin
			sum_q <= 8'h00;
		end else if (push_ok && idx_q >= brs_pkg::FIRST_SUMMED && idx_q < 4'hd) begin
			sum_q <= sum_q + cur_byte;
		end
	end

	// Flash status is cleared only once the whole reply is queued
	assign flash_status_clear_o = (state_q == brs_pkg::BRS_CLEAR);
endmodule : brs_encoder

// *** sim/brs_encoder_monitor.sv ***
`timescale 1ns/1ns
module brs_encoder_monitor (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_valid_i,
	input wire logic req_ready_o,
	input wire logic [7:0] cmd_code_i,
	input wire logic cmd_supported_i,
	input wire logic [7:0] lifecycle_monitor_i,
	input wire logic flash_status_clear_o,
	input wire logic [7:0] response_code_o,
	input wire logic [7:0] status_code_o,
	input wire logic [7:0] lifecycle_state_o,
	input wire logic tx_valid_o,
	input wire logic tx_ready_i,
	input wire logic [7:0] tx_data_o
);
	logic take;
	// A request is taken when it meets an idle encoder
	assign take = req_valid_i && req_ready_o;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	AST_ERR_FLAG: assert property (take |=> response_code_o ==
		($past(cmd_code_i) | {status_code_o != 8'h00, 7'h00})) else $error("bad flag");
	AST_UNSUPPORTED: assert property (take && !cmd_supported_i |=>
		status_code_o == 8'hc0) else $error("unsupported not reported");
	AST_CLEAR_SPAN: assert property (take |=>
		!flash_status_clear_o [*8] ##[8:400] flash_status_clear_o) else $error("clear timing");
	AST_CLEAR_PULSE: assert property (flash_status_clear_o |=>
		req_ready_o && !flash_status_clear_o) else $error("clear pulse");
	AST_BUSY: assert property (take |=> !req_ready_o) else $error("ready after take");
	AST_FIRST_BYTE: assert property (take && !tx_valid_o |->
		##2 tx_valid_o && tx_data_o == 8'h81) else $error("first byte");
	AST_HOLD: assert property (tx_valid_o && !tx_ready_i |=>
		tx_valid_o && $stable(tx_data_o)) else $error("byte not held");
	AST_STANDS: assert property (!take |=> $stable(status_code_o) &&
		$stable(response_code_o)) else $error("summary moved");
	AST_LC_RANGE: assert property (take |=> lifecycle_state_o ==
		(($past(lifecycle_monitor_i) >= 8'h01 && $past(lifecycle_monitor_i) <= 8'h08) ?
		$past(lifecycle_monitor_i) : 8'h00)) else $error("lifecycle code range");
endmodule : brs_encoder_monitor

bind brs_encoder brs_encoder_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
	.req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .cmd_code_i(cmd_code_i),
	.cmd_supported_i(cmd_supported_i), .lifecycle_monitor_i(lifecycle_monitor_i),
	.flash_status_clear_o(flash_status_clear_o),
	.response_code_o(response_code_o), .status_code_o(status_code_o),
	.lifecycle_state_o(lifecycle_state_o), .tx_valid_o(tx_valid_o),
	.tx_ready_i(tx_ready_i), .tx_data_o(tx_data_o));

// *** sim/brs_host_model.sv ***
`timescale 1ns/1ns
module brs_host_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic stall_i,
	input wire logic valid_i,
	input wire logic [7:0] data_i,
	output logic ready_o
);
	logic [7:0] rx[$];
	// A stalled host lets the reply back up into the encoder buffer
	assign ready_o = !stall_i && !rst_i;
	// Collect reply bytes in arrival order
	always @(posedge clk_i) begin
		if (!rst_i && valid_i && ready_o) begin
			rx.push_back(data_i);
		end
	end
endmodule : brs_host_model

// *** sim/boot_response_status_encoder_tb_top.sv ***
`timescale 1ns/1ns
module boot_response_status_encoder_tb_top;
	logic clk_i, rst_i, req_valid_i, req_ready_o, cmd_supported_i, stall;
	logic err_packet_i, err_checksum_i, err_param_i, err_protect_i, err_secure_i;
	logic trusted_fault_i, flash_cmd_lock_i, flash_status_clear_o, tx_valid_o, tx_ready_i;
	logic [7:0] cmd_code_i, cmd_lc_mask_i, lifecycle_monitor_i, stored_lifecycle_info_i;
	logic [7:0] response_code_o, status_code_o, lifecycle_state_o, tx_data_o;
	logic [31:0] flash_status_word_i, flash_fail_addr_i;
	logic id_auth_fail_i, id_authenticated_i, stored_id_top_i;
	logic [1:0] cmd_auth_mask_i;
	logic [7:0] id_resp, id_status, id_lc;
	int n_mismatch, checked;
	brs_encoder #(.LC_CAPABLE(1'h1), .FIFO_DEPTH(8)) DUT (
		.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
		.cmd_code_i(cmd_code_i), .cmd_supported_i(cmd_supported_i),
		.err_packet_i(err_packet_i), .err_checksum_i(err_checksum_i), .err_param_i(err_param_i),
		.err_protect_i(err_protect_i), .err_secure_i(err_secure_i),
		.trusted_fault_i(trusted_fault_i), .id_auth_fail_i(id_auth_fail_i),
		.cmd_lc_mask_i(cmd_lc_mask_i), .cmd_auth_mask_i(cmd_auth_mask_i),
		.id_authenticated_i(id_authenticated_i),
		.stored_id_top_i(stored_id_top_i), .lifecycle_monitor_i(lifecycle_monitor_i),
		.stored_lifecycle_info_i(stored_lifecycle_info_i), .flash_cmd_lock_i(flash_cmd_lock_i),
		.flash_status_word_i(flash_status_word_i), .flash_fail_addr_i(flash_fail_addr_i),
		.flash_status_clear_o(flash_status_clear_o), .response_code_o(response_code_o),
		.status_code_o(status_code_o), .lifecycle_state_o(lifecycle_state_o),
		.tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .tx_data_o(tx_data_o));
	// Identity-group build on the same requests; its stream is always drained
	brs_encoder #(.LC_CAPABLE(1'h0)) DUT_ID (
		.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_ready_o(),
		.cmd_code_i(cmd_code_i), .cmd_supported_i(cmd_supported_i),
		.err_packet_i(err_packet_i), .err_checksum_i(err_checksum_i), .err_param_i(err_param_i),
		.err_protect_i(err_protect_i), .err_secure_i(err_secure_i),
		.trusted_fault_i(trusted_fault_i), .id_auth_fail_i(id_auth_fail_i),
		.cmd_lc_mask_i(cmd_lc_mask_i), .cmd_auth_mask_i(cmd_auth_mask_i),
		.id_authenticated_i(id_authenticated_i), .stored_id_top_i(stored_id_top_i),
		.lifecycle_monitor_i(lifecycle_monitor_i),
		.stored_lifecycle_info_i(stored_lifecycle_info_i), .flash_cmd_lock_i(flash_cmd_lock_i),
		.flash_status_word_i(flash_status_word_i), .flash_fail_addr_i(flash_fail_addr_i),
		.flash_status_clear_o(), .response_code_o(id_resp),
		.status_code_o(id_status), .lifecycle_state_o(id_lc),
		.tx_valid_o(), .tx_ready_i(1'h1), .tx_data_o());
	brs_host_model host (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .valid_i(tx_valid_o),
		.data_i(tx_data_o), .ready_o(tx_ready_i));
	// Byte compare with counting
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Present one request, then check the summary once it is taken
	task automatic issue(input logic [7:0] c, e, lc, sl, m, st, lcx);
		int n;
		n = 0;
		@(negedge clk_i);
		cmd_code_i = c;
		{flash_cmd_lock_i, trusted_fault_i, err_secure_i, err_protect_i} = e[7:4];
		{err_param_i, err_checksum_i, err_packet_i} = e[3:1];
		cmd_supported_i = !e[0];
		lifecycle_monitor_i = lc;
		stored_lifecycle_info_i = sl;
		cmd_lc_mask_i = m;
		req_valid_i = 1'h1;
		while (req_ready_o !== 1'h1 && n < 200) begin
			@(negedge clk_i);
			n++;
		end
		@(negedge clk_i);
		req_valid_i = 1'h0;
		chk(response_code_o, c | (st != 8'h00 ? 8'h80 : 8'h00));
		chk(status_code_o, st);
		chk(lifecycle_state_o, lcx);
	endtask : issue
	// Take one 15-byte reply from the host and compare with the expected frame
	task automatic check(input logic [7:0] c, st, input logic fl);
		logic [31:0] d, a;
		logic [7:0] b[15];
		int n;
		n = 0;
		d = fl ? flash_status_word_i : brs_pkg::UNUSED_CODE;
		a = fl ? flash_fail_addr_i : brs_pkg::UNUSED_CODE;
		b = '{8'h81, 8'h00, 8'h0a, c | (st != 8'h00 ? 8'h80 : 8'h00), st, d[31:24], d[23:16],
			d[15:8], d[7:0], a[31:24], a[23:16], a[15:8], a[7:0], 8'h00, 8'h03};
		for (int i = 1; i < 13; i++) begin
			b[13] = b[13] - b[i];
		end
		while (host.rx.size() < 15 && n < 400) begin
			@(negedge clk_i);
			n++;
		end
		for (int i = 0; i < 15; i++) begin
			chk(host.rx.size() != 0 ? host.rx.pop_front() : 8'hxx, b[i]);
		end
	endtask : check
	// Every lifecycle code with the command allowed, then one masked out
	task automatic t_lifecycle();
		for (int lc = 1; lc <= 8; lc++) begin
			issue(8'h2c, 8'h00, 8'(lc), 8'(lc), 8'hff, lc == 6 ? 8'hd5 : 8'h00, 8'(lc));
			check(8'h2c, lc == 6 ? 8'hd5 : 8'h00, 1'h0);
		end
		issue(8'h13, 8'h00, 8'h04, 8'h04, 8'hf7, 8'hd5, 8'h04);
		check(8'h13, 8'hd5, 1'h0);
	endtask : t_lifecycle
	// Each error input alone, all at once, and both lifecycle faults
	task automatic t_errors();
		logic [7:0] ev[9] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'hff};
		logic [7:0] sv[9] = '{8'hc0, 8'hc1, 8'hc2, 8'hd0, 8'hda, 8'he4, 8'hdb, 8'he5, 8'hc0};
		for (int i = 0; i < 9; i++) begin
			issue(8'h12, ev[i], 8'h04, 8'h04, 8'hff, sv[i], 8'h04);
			check(8'h12, sv[i], i == 7);
		end
		issue(8'h15, 8'h00, 8'h04, 8'h03, 8'hff, 8'hd6, 8'h04);
		check(8'h15, 8'hd6, 1'h0);
		issue(8'h15, 8'h00, 8'h09, 8'h09, 8'hff, 8'hd7, 8'h00);
		check(8'h15, 8'hd7, 1'h0);
	endtask : t_errors
	// Host stalls: the buffer fills and the flash status is not cleared early
	task automatic t_stall();
		stall = 1'h1;
		issue(8'h18, 8'h80, 8'h04, 8'h04, 8'hff, 8'he5, 8'h04);
		repeat (40) @(negedge clk_i);
		chk({7'h0, tx_valid_o}, 8'h01);
		chk({7'h0, req_ready_o}, 8'h00);
		stall = 1'h0;
		check(8'h18, 8'he5, 1'h1);
	endtask : t_stall
	// Second request taken before the first reply is read back from the host
	task automatic t_back_to_back();
		issue(8'h3a, 8'h00, 8'h02, 8'h02, 8'hff, 8'h00, 8'h02);
		issue(8'h3b, 8'h08, 8'h02, 8'h02, 8'hff, 8'hd0, 8'h02);
		check(8'h3a, 8'h00, 1'h0);
		check(8'h3b, 8'hd0, 1'h0);
	endtask : t_back_to_back
	// Identity build: serial disable, auth state, ID failure; lifecycle-only faults ignored
	task automatic t_id_group();
		logic [4:0] f[5] = '{5'h06, 5'h05, 5'h1d, 5'h03, 5'h07};
		logic [7:0] ev[5] = '{8'h00, 8'h00, 8'h00, 8'h20, 8'h00};
		logic [7:0] lv[5] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h09};
		logic [7:0] sv[5] = '{8'h00, 8'h00, 8'h00, 8'he4, 8'hd7};
		logic [7:0] iv[5] = '{8'hde, 8'hd5, 8'hdd, 8'h00, 8'h00};
		for (int i = 0; i < 5; i++) begin
			{id_auth_fail_i, id_authenticated_i, cmd_auth_mask_i, stored_id_top_i} = f[i];
			issue(8'h30, ev[i], lv[i], lv[i], 8'hff, sv[i], i == 4 ? 8'h00 : 8'h04);
			chk(id_status, iv[i]);
			chk(id_resp, 8'h30 | (iv[i] != 8'h00 ? 8'h80 : 8'h00));
			chk(id_lc, i == 4 ? 8'h00 : 8'h04);
		end
	endtask : t_id_group
	// Print the counts and the verdict, then stop
	task automatic summarize();
		$display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize
	// Clock at 250 MHz
	initial begin
		clk_i = 1'h0;
		forever #2 clk_i = ~clk_i;
	end
	// Watchdog well beyond the expected run
	initial begin
		repeat (8000) @(posedge clk_i);
		n_mismatch++;
		summarize();
	end
	// Reset, then the scenarios
	initial begin
		n_mismatch = 0;
		checked = 0;
		rst_i = 1'h1;
		{req_valid_i, cmd_supported_i, err_packet_i, err_checksum_i, err_param_i} = 5'h0;
		{err_protect_i, err_secure_i, trusted_fault_i, flash_cmd_lock_i, stall} = 5'h0;
		{cmd_code_i, cmd_lc_mask_i, lifecycle_monitor_i, stored_lifecycle_info_i} = 32'h0;
		{id_auth_fail_i, id_authenticated_i, cmd_auth_mask_i, stored_id_top_i} = 5'h07;
		flash_status_word_i = 32'h00008010;
		flash_fail_addr_i = 32'h00012340;
		repeat (6) @(posedge clk_i);
		@(negedge clk_i);
		rst_i = 1'h0;
		t_lifecycle();
		t_errors();
		t_stall();
		t_back_to_back();
		t_id_group();
		summarize();
	end
endmodule : boot_response_status_encoder_tb_top
